// file: mxa_core.sv
// External data access, program fetch and pointer logic of the CPU core
`timescale 1ns/1ps
// Contract
// - Program addresses span the whole 16-bit range and serve instruction fetches.
// - After reset the fetch address starts at zero.
// - Interrupt vectors start at address three and step by eight bytes.
// - Data accesses reach storage only in the EXTERNAL_WORK_RAM, engine data, I/O and engine program ranges.
// - Ri and pointer MOVX forms produce external reads and writes.
// - Paged MOVX takes the low byte from R0/and the high byte from the page register.
// - Pointer MOVX takes all sixteen bits from the active data pointer.
// - The stretch value is the low three bits of the stretch register and applies to every MOVX.
// - A read with stretch n holds address and read strobe for n+1 cycles.
// - A write with stretch n holds address n+2 cycles and strobe 1 cycle for n<2, else n.
// - The stretch register resets to one.
// - Bit 0 of the pointer-select register picks secondary when set, primary when clear.
// - Pointer instructions touch only the selected pointer.
// - Fetch is held off while a MOVX is busy, at most one fetch per machine cycle.
// - The CPU clock is divided by a three-bit field software writes.
module mxa_core (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // CPU side
   input  wire logic [2:0]  op,
   input  wire logic [7:0]  ri_val,
   input  wire logic [7:0]  op_wdata,
   input  wire logic [15:0] dp_load,
   input  wire logic        fetch_req,
   input  wire logic        fetch_branch,
   input  wire logic [15:0] fetch_target,
   input  wire logic        irq_take,
   input  wire logic [2:0]  irq_num,
   output logic             op_busy,
   output logic             op_done,
   output logic [7:0]       op_rdata,
   output logic [15:0]      pc_addr,
   output logic             pc_fetch,
   output logic             cpu_en_q,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   // Memory side
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   output logic             mem_rd,
   output logic             mem_wr,
   output logic [3:0]       mem_sel,
   input  wire logic [7:0]  external_work_ram_rdata,
   input  wire logic [7:0]  dram_rdata,
   input  wire logic [7:0]  ioram_rdata,
   input  wire logic [7:0]  pram_rdata
);
   logic [7:0]           stretch_control_q;
   logic [7:0]           page_high_address_q;
   logic [7:0]           pointer_select_q;
   logic [15:0]          primary_data_pointer_q;
   logic [15:0]          secondary_data_pointer_q;
   logic [2:0]           cpu_clock_divider_q;
   mxa_pkg::mxa_state_t  state_q;
   logic [3:0]           cnt_q;
   logic [3:0]           strb_len_q;
   logic                 is_wr_q;
   logic [3:0]           sel_q;
   logic [15:0]          acc_addr;
   logic                 is_rd_op;
   logic                 is_wr_op;
   logic [2:0]           stretch;
   logic [15:0]          act_dp;
   logic                 cpu_en;
   logic [7:0]           rsel_data;

   // Range decode used for select and read steering
   function automatic logic [3:0] mxa_decode(input logic [15:0] a);
      logic [3:0] s;
      s    = 4'h0;
      s[0] = (a <= mxa_pkg::MXA_EXTERNAL_WORK_RAM_HI);
      s[1] = (a >= mxa_pkg::MXA_DRAM_LO) && (a <= mxa_pkg::MXA_DRAM_HI);
      s[2] = (a >= mxa_pkg::MXA_IORAM_LO) && (a <= mxa_pkg::MXA_IORAM_HI);
      s[3] = (a >= mxa_pkg::MXA_PRAM_LO) && (a <= mxa_pkg::MXA_PRAM_HI);
      return s;
   endfunction : mxa_decode

   mxa_clkdiv u_div (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .div_sel (cpu_clock_divider_q),
      .cpu_en  (cpu_en)
   );

   assign stretch  = stretch_control_q[mxa_pkg::MXA_STRETCH_LSB +: 3];
   assign act_dp   = pointer_select_q[mxa_pkg::MXA_PSEL_BIT] ? secondary_data_pointer_q
                                                              : primary_data_pointer_q;
   assign is_rd_op = (op == mxa_pkg::MXA_OP_RD_RI) || (op == mxa_pkg::MXA_OP_RD_PRIMARY_DATA_POINTER);
   assign is_wr_op = (op == mxa_pkg::MXA_OP_WR_RI) || (op == mxa_pkg::MXA_OP_WR_PRIMARY_DATA_POINTER);
   assign acc_addr = ((op == mxa_pkg::MXA_OP_RD_RI) || (op == mxa_pkg::MXA_OP_WR_RI))
                     ? {page_high_address_q, ri_val}
                     : act_dp;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cpu_en_q <= 1'b0;
      end else begin
         cpu_en_q <= cpu_en;
      end
   end

   // Software registers
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stretch_control_q   <= mxa_pkg::MXA_STRETCH_RST;
         page_high_address_q <= mxa_pkg::MXA_PAGE_RST;
         pointer_select_q    <= mxa_pkg::MXA_PSEL_RST;
         cpu_clock_divider_q <= mxa_pkg::MXA_DIV_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            mxa_pkg::MXA_OFS_STRETCH: stretch_control_q   <= reg_wdata;
            mxa_pkg::MXA_OFS_PAGE:    page_high_address_q <= reg_wdata;
            mxa_pkg::MXA_OFS_PSEL:    pointer_select_q    <= reg_wdata;
            mxa_pkg::MXA_OFS_DIV:     cpu_clock_divider_q <= reg_wdata[2:0];
            default: ;
         endcase
      end
   end

   // Data pointers; pointer ops change only the selected one, register writes either
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         primary_data_pointer_q   <= mxa_pkg::MXA_PRIMARY_DATA_POINTER_RST;
         secondary_data_pointer_q <= mxa_pkg::MXA_PRIMARY_DATA_POINTER_RST;
      end else if (reg_wr && reg_addr == mxa_pkg::MXA_OFS_DPL0) begin
         primary_data_pointer_q[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == mxa_pkg::MXA_OFS_DPH0) begin
         primary_data_pointer_q[15:8] <= reg_wdata;
      end else if (reg_wr && reg_addr == mxa_pkg::MXA_OFS_DPL1) begin
         secondary_data_pointer_q[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == mxa_pkg::MXA_OFS_DPH1) begin
         secondary_data_pointer_q[15:8] <= reg_wdata;
      end else if (state_q == mxa_pkg::MXA_ST_IDLE && cpu_en_q) begin
         if (op == mxa_pkg::MXA_OP_INC_DP || op == mxa_pkg::MXA_OP_LOAD_DP) begin
            if (pointer_select_q[mxa_pkg::MXA_PSEL_BIT]) begin
               secondary_data_pointer_q <= (op == mxa_pkg::MXA_OP_LOAD_DP) ? dp_load
                                           : secondary_data_pointer_q + 16'h0001;
            end else begin
               primary_data_pointer_q <= (op == mxa_pkg::MXA_OP_LOAD_DP) ? dp_load
                                         : primary_data_pointer_q + 16'h0001;
            end
         end
      end
   end

   // MOVX sequencer: address phase, strobe, done
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q    <= mxa_pkg::MXA_ST_IDLE;
         cnt_q      <= 4'h0;
         strb_len_q <= 4'h0;
         is_wr_q    <= 1'b0;
         sel_q      <= 4'h0;
         mem_addr   <= 16'h0000;
         mem_wdata  <= 8'h00;
         mem_rd     <= 1'b0;
         mem_wr     <= 1'b0;
         mem_sel    <= 4'h0;
         op_busy    <= 1'b0;
         op_done    <= 1'b0;
         op_rdata   <= 8'h00;
      end else begin
         op_done <= 1'b0;
         case (state_q)
            mxa_pkg::MXA_ST_IDLE: begin
               if (cpu_en_q && (is_rd_op || is_wr_op)) begin
                  mem_addr  <= acc_addr;
                  mem_wdata <= op_wdata;
                  sel_q     <= mxa_decode(acc_addr);
                  is_wr_q   <= is_wr_op;
                  op_busy   <= 1'b1;
                  if (is_rd_op) begin
                     mem_rd     <= 1'b1;
                     mem_sel    <= mxa_decode(acc_addr);
                     cnt_q      <= {1'b0, stretch};
                     strb_len_q <= 4'h0;
                     state_q    <= mxa_pkg::MXA_ST_STRB;
                  end else begin
                     // Write: one lead-in cycle except at stretch 0
                     strb_len_q <= (stretch < 3'd2) ? 4'h1 : {1'b0, stretch};
                     cnt_q      <= 4'h0;
                     if (stretch == 3'd0) begin
                        mem_wr  <= 1'b1;
                        mem_sel <= mxa_decode(acc_addr);
                        state_q <= mxa_pkg::MXA_ST_STRB;
                     end else begin
                        state_q <= mxa_pkg::MXA_ST_ADDR;
                     end
                  end
               end
            end
            mxa_pkg::MXA_ST_ADDR: begin
               if (cnt_q == 4'h0) begin
                  mem_wr  <= 1'b1;
                  mem_sel <= sel_q;
                  cnt_q   <= strb_len_q - 4'h1;
                  state_q <= mxa_pkg::MXA_ST_STRB;
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            mxa_pkg::MXA_ST_STRB: begin
               if (cnt_q == 4'h0) begin
                  mem_rd  <= 1'b0;
                  mem_wr  <= 1'b0;
                  mem_sel <= 4'h0;
                  if (!is_wr_q) begin
                     op_rdata <= rsel_data;
                     op_busy  <= 1'b0;
                     op_done  <= 1'b1;
                     state_q  <= mxa_pkg::MXA_ST_IDLE;
                  end else begin
                     state_q <= mxa_pkg::MXA_ST_DONE;
                  end
               end else begin
                  cnt_q <= cnt_q - 4'h1;
               end
            end
            mxa_pkg::MXA_ST_DONE: begin
               op_busy <= 1'b0;
               op_done <= 1'b1;
               state_q <= mxa_pkg::MXA_ST_IDLE;
            end
            default: state_q <= mxa_pkg::MXA_ST_IDLE;
         endcase
      end
   end

   // Read steering; unmapped reads give zero
   always_comb begin
      case (sel_q)
         4'h1:    rsel_data = external_work_ram_rdata;
         4'h2:    rsel_data = dram_rdata;
         4'h4:    rsel_data = ioram_rdata;
         4'h8:    rsel_data = pram_rdata;
         default: rsel_data = 8'h00;
      endcase
   end

   // Program fetch address, one fetch per enabled cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pc_addr  <= mxa_pkg::MXA_RESET_PC;
         pc_fetch <= 1'b0;
      end else begin
         pc_fetch <= 1'b0;
         if (cpu_en_q && fetch_req && !op_busy) begin
            pc_fetch <= 1'b1;
            if (irq_take) begin
               pc_addr <= mxa_pkg::MXA_VEC_FIRST + 16'({irq_num, 3'b000});
            end else if (fetch_branch) begin
               pc_addr <= fetch_target;
            end else begin
               pc_addr <= pc_addr + 16'h0001;
            end
         end
      end
   end

   // Register read port, data one cycle later
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            mxa_pkg::MXA_OFS_STRETCH: reg_rdata <= stretch_control_q;
            mxa_pkg::MXA_OFS_PAGE:    reg_rdata <= page_high_address_q;
            mxa_pkg::MXA_OFS_PSEL:    reg_rdata <= pointer_select_q;
            mxa_pkg::MXA_OFS_DPL0:    reg_rdata <= primary_data_pointer_q[7:0];
            mxa_pkg::MXA_OFS_DPH0:    reg_rdata <= primary_data_pointer_q[15:8];
            mxa_pkg::MXA_OFS_DPL1:    reg_rdata <= secondary_data_pointer_q[7:0];
            mxa_pkg::MXA_OFS_DPH1:    reg_rdata <= secondary_data_pointer_q[15:8];
            mxa_pkg::MXA_OFS_DIV:     reg_rdata <= {5'h00, cpu_clock_divider_q};
            mxa_pkg::MXA_OFS_STATUS:  reg_rdata <= {4'h0, is_wr_q, op_busy, state_q};
            mxa_pkg::MXA_OFS_PC_LO:   reg_rdata <= pc_addr[7:0];
            mxa_pkg::MXA_OFS_PC_HI:   reg_rdata <= pc_addr[15:8];
            default:                  reg_rdata <= 8'h00;
         endcase
      end
   end
endmodule : mxa_core

// file: mxa_pkg.sv
// Constants and types for the external data access block
package mxa_pkg;
   localparam logic [15:0] MXA_RESET_PC     = 16'h0000;
   localparam logic [15:0] MXA_VEC_FIRST    = 16'h0003;
   localparam logic [15:0] MXA_VEC_STEP     = 16'h0008;
   localparam logic [15:0] MXA_EXTERNAL_WORK_RAM_LO      = 16'h0000;
   localparam logic [15:0] MXA_EXTERNAL_WORK_RAM_HI      = 16'h07FF;
   localparam logic [15:0] MXA_DRAM_LO      = 16'h1000;
   localparam logic [15:0] MXA_DRAM_HI      = 16'h13FF;
   localparam logic [15:0] MXA_IORAM_LO     = 16'h2000;
   localparam logic [15:0] MXA_IORAM_HI     = 16'h20FF;
   localparam logic [15:0] MXA_PRAM_LO      = 16'h3000;
   localparam logic [15:0] MXA_PRAM_HI      = 16'h3FFF;
   localparam logic [7:0]  MXA_STRETCH_RST  = 8'h01;
   localparam logic [7:0]  MXA_PAGE_RST     = 8'h00;
   localparam logic [7:0]  MXA_PSEL_RST     = 8'h00;
   localparam logic [15:0] MXA_PRIMARY_DATA_POINTER_RST     = 16'h0000;
   localparam logic [2:0]  MXA_DIV_RST      = 3'h0;
   localparam int          MXA_STRETCH_LSB  = 0;
   localparam int          MXA_PSEL_BIT     = 0;
   localparam logic [7:0]  MXA_OFS_STRETCH  = 8'h8E;
   localparam logic [7:0]  MXA_OFS_PAGE     = 8'hBF;
   localparam logic [7:0]  MXA_OFS_PSEL     = 8'h92;
   localparam logic [7:0]  MXA_OFS_DPL0     = 8'h82;
   localparam logic [7:0]  MXA_OFS_DPH0     = 8'h83;
   localparam logic [7:0]  MXA_OFS_DPL1     = 8'h84;
   localparam logic [7:0]  MXA_OFS_DPH1     = 8'h85;
   localparam logic [7:0]  MXA_OFS_DIV      = 8'hC1;
   localparam logic [7:0]  MXA_OFS_STATUS   = 8'hC2;
   localparam logic [7:0]  MXA_OFS_PC_LO    = 8'hC3;
   localparam logic [7:0]  MXA_OFS_PC_HI    = 8'hC4;

   typedef enum logic [1:0] {
      MXA_TGT_EXTERNAL_WORK_RAM  = 2'b00,
      MXA_TGT_DRAM  = 2'b01,
      MXA_TGT_IORAM = 2'b10,
      MXA_TGT_PRAM  = 2'b11
   } mxa_tgt_t;

   typedef enum logic [1:0] {
      MXA_ST_IDLE = 2'b00,
      MXA_ST_ADDR = 2'b01,
      MXA_ST_STRB = 2'b10,
      MXA_ST_DONE = 2'b11
   } mxa_state_t;

   typedef enum logic [2:0] {
      MXA_OP_NONE    = 3'b000,
      MXA_OP_RD_RI   = 3'b001,
      MXA_OP_WR_RI   = 3'b010,
      MXA_OP_RD_PRIMARY_DATA_POINTER = 3'b011,
      MXA_OP_WR_PRIMARY_DATA_POINTER = 3'b100,
      MXA_OP_INC_DP  = 3'b101,
      MXA_OP_LOAD_DP = 3'b110
   } mxa_op_t;
endpackage : mxa_pkg

// file: mxa_clkdiv.sv
// CPU clock enable divider
`timescale 1ns/1ps
module mxa_clkdiv (
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [2:0] div_sel,
   output logic            cpu_en
);
   logic [7:0] cnt_q;
   logic [7:0] limit;

   // Divide by 2^div_sel
   assign limit = 8'((9'h001 << div_sel) - 9'h001);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cnt_q  <= 8'h00;
         cpu_en <= 1'b0;
      end else if (cnt_q >= limit) begin
         cnt_q  <= 8'h00;
         cpu_en <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 8'h01;
         cpu_en <= 1'b0;
      end
   end
endmodule : mxa_clkdiv

// file: mxa_mem_model.sv
// Behavioural model of the on-chip data memories
`timescale 1ns/1ps
module mxa_mem_model (
   input  wire logic        mclk,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   input  wire logic        mem_wr,
   input  wire logic [3:0]  mem_sel,
   output logic [7:0]       external_work_ram_rdata,
   output logic [7:0]       dram_rdata,
   output logic [7:0]       ioram_rdata,
   output logic [7:0]       pram_rdata
);
   logic [7:0] external_work_ram  [2048];
   logic [7:0] dram  [1024];
   logic [7:0] ioram [256];
   logic [7:0] pram  [4096];
   logic [7:0] junk_q = 8'h5A;
   // Unselected outputs churn
   always_ff @(posedge mclk) begin
      junk_q <= junk_q + 8'h3B;
      if (mem_wr && mem_sel[0]) external_work_ram[mem_addr[10:0]] <= mem_wdata;
      if (mem_wr && mem_sel[1]) dram[mem_addr[9:0]] <= mem_wdata;
      if (mem_wr && mem_sel[2]) ioram[mem_addr[7:0]] <= mem_wdata;
      if (mem_wr && mem_sel[3]) pram[mem_addr[11:0]] <= mem_wdata;
   end
   assign external_work_ram_rdata  = mem_sel[0] ? external_work_ram[mem_addr[10:0]] : junk_q;
   assign dram_rdata  = mem_sel[1] ? dram[mem_addr[9:0]] : junk_q;
   assign ioram_rdata = mem_sel[2] ? ioram[mem_addr[7:0]] : junk_q;
   assign pram_rdata  = mem_sel[3] ? pram[mem_addr[11:0]] : junk_q;
endmodule : mxa_mem_model

// file: mxa_core_chk.sv
// Port assertions for the external data access block
`timescale 1ns/1ps
module mxa_core_chk (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        op_done,
   input wire logic [15:0] pc_addr,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic [15:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic [3:0]  mem_sel
);
   logic [2:0] str_q;
   logic [3:0] rd_cnt_q;
   logic [3:0] wr_cnt_q;
   logic [3:0] exp_sel;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Shadow of stretch value and strobe widths
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         str_q    <= 3'h1;
         rd_cnt_q <= 4'h0;
         wr_cnt_q <= 4'h0;
      end else begin
         if (reg_wr && reg_addr == 8'h8E) str_q <= reg_wdata[2:0];
         rd_cnt_q <= mem_rd ? rd_cnt_q + 4'h1 : 4'h0;
         wr_cnt_q <= mem_wr ? wr_cnt_q + 4'h1 : 4'h0;
      end
   end
   always_comb begin
      exp_sel = 4'h0;
      if (mem_addr <= 16'h07FF) exp_sel = 4'h1;
      if (mem_addr >= 16'h1000 && mem_addr <= 16'h13FF) exp_sel = 4'h2;
      if (mem_addr >= 16'h2000 && mem_addr <= 16'h20FF) exp_sel = 4'h4;
      if (mem_addr >= 16'h3000 && mem_addr <= 16'h3FFF) exp_sel = 4'h8;
   end
   AST_RD_WIDTH: assert property ($fell(mem_rd) |-> rd_cnt_q == {1'b0, str_q} + 4'h1)
      else $error("read strobe width wrong");
   AST_WR_WIDTH: assert property ($fell(mem_wr) |-> wr_cnt_q == (str_q < 3'h2 ? 4'h1 : {1'b0, str_q}))
      else $error("write strobe width wrong");
   AST_RD_DONE: assert property ($fell(mem_rd) |-> op_done)
      else $error("read end without done");
   AST_STRB_EXCL: assert property (!(mem_rd && mem_wr))
      else $error("read and write strobes together");
   AST_SEL_DECODE: assert property ((mem_rd || mem_wr) |-> mem_sel == exp_sel)
      else $error("memory select wrong for address");
   AST_ADDR_STABLE: assert property ((mem_rd && $past(mem_rd)) || (mem_wr && $past(mem_wr)) |-> $stable(mem_addr))
      else $error("address moved during strobe");
   AST_REG_STRETCH: assert property (reg_rd && reg_addr == 8'h8E |=> reg_rdata[2:0] == $past(str_q))
      else $error("stretch register value wrong");
   AST_PC_RESET: assert property ($rose(rst_n) |-> pc_addr == 16'h0000)
      else $error("fetch address not zero after reset");
   COV_WR7: cover property ($fell(mem_wr) && str_q == 3'h7);
   COV_IORD: cover property (mem_rd && mem_sel == 4'h4);
   COV_UNMAP: cover property (mem_wr && mem_sel == 4'h0);
endmodule : mxa_core_chk
bind mxa_core mxa_core_chk u_mxa_core_chk (.mclk, .rst_n, .op_done, .pc_addr, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_sel);

// file: mxa_core_tb.sv
// Testbench for the external data access block
`timescale 1ns/1ps
module mxa_core_tb;
   logic        mclk, rst_n, fetch_req, fetch_branch, irq_take, op_busy, op_done, pc_fetch, cpu_en_q;
   logic        reg_wr, reg_rd, mem_rd, mem_wr;
   logic [2:0]  op, irq_num;
   logic [7:0]  ri_val, op_wdata, op_rdata, reg_addr, reg_wdata, reg_rdata, mem_wdata, m_rd;
   logic [7:0]  external_work_ram_rdata, dram_rdata, ioram_rdata, pram_rdata;
   logic [15:0] dp_load, fetch_target, pc_addr, mem_addr, m_adr;
   logic [3:0]  mem_sel, m_sel;
   int          n_errors, n_tests, m_nrd, m_nwr, m_nbz;
   logic [15:0] dec_adr [10] = '{16'h0000, 16'h07FF, 16'h1000, 16'h13FF, 16'h2000, 16'h20FF, 16'h3000,
                                 16'h3FFF, 16'h0800, 16'h4000};
   logic [3:0]  dec_sel [10] = '{4'h1, 4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8, 4'h8, 4'h0, 4'h0};
   mxa_core u_mxa_core (.mclk(mclk), .rst_n(rst_n), .op(op), .ri_val(ri_val), .op_wdata(op_wdata),
      .dp_load(dp_load), .fetch_req(fetch_req), .fetch_branch(fetch_branch), .fetch_target(fetch_target),
      .irq_take(irq_take), .irq_num(irq_num), .op_busy(op_busy), .op_done(op_done), .op_rdata(op_rdata),
      .pc_addr(pc_addr), .pc_fetch(pc_fetch), .cpu_en_q(cpu_en_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_sel(mem_sel), .external_work_ram_rdata(external_work_ram_rdata), .dram_rdata(dram_rdata),
      .ioram_rdata(ioram_rdata), .pram_rdata(pram_rdata));
   mxa_mem_model u_mxa_mem_model (.mclk(mclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
      .mem_sel(mem_sel), .external_work_ram_rdata(external_work_ram_rdata), .dram_rdata(dram_rdata), .ioram_rdata(ioram_rdata),
      .pram_rdata(pram_rdata));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask : wr_reg
   task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1 chk(what, {8'h00, exp}, {8'h00, reg_rdata});
   endtask : chk_reg
   task automatic set_dp(input logic [15:0] v);
      wr_reg(8'h82, v[7:0]);
      wr_reg(8'h83, v[15:8]);
   endtask : set_dp
   task automatic pulse_op(input logic [2:0] o, input logic [7:0] ri, input logic [7:0] wd, input logic [15:0] v);
      @(posedge mclk);
      op       <= o;
      ri_val   <= ri;
      op_wdata <= wd;
      dp_load  <= v;
      @(posedge mclk);
      op       <= 3'h0;
   endtask : pulse_op
   // Issue one access, count strobe and busy cycles until done
   task automatic movx(input logic [2:0] o, input logic [7:0] ri, input logic [7:0] wd);
      pulse_op(o, ri, wd, 16'h0000);
      m_nrd = 0;
      m_nwr = 0;
      m_nbz = 0;
      for (int i = 0; i < 24; i++) begin
         #1;
         m_nrd += int'(mem_rd === 1'b1);
         m_nwr += int'(mem_wr === 1'b1);
         m_nbz += int'(op_busy === 1'b1);
         if (mem_rd === 1'b1 || mem_wr === 1'b1) begin
            m_adr = mem_addr;
            m_sel = mem_sel;
         end
         if (op_done === 1'b1) begin
            m_rd = op_rdata;
            return;
         end
         @(posedge mclk);
      end
      chk("op_done", 16'h0001, 16'h0000);
   endtask : movx
   task automatic wait_pc(input logic [15:0] exp);
      for (int i = 0; i < 4 && pc_addr !== exp; i++) @(posedge mclk);
      #1 chk("pc_addr", exp, pc_addr);
   endtask : wait_pc
   task automatic t_reset;
      chk("pc reset", 16'h0000, pc_addr);
      chk_reg("stretch", 8'h8E, 8'h01);
      chk_reg("page", 8'hBF, 8'h00);
      chk_reg("select", 8'h92, 8'h00);
      chk_reg("unmapped reg", 8'hF0, 8'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_stretch;
      for (int n = 0; n < 8; n++) begin
         wr_reg(8'h8E, 8'hF8 | 8'(n));
         set_dp(16'h0100 + 16'(n));
         movx(3'h4, 8'h00, 8'h50 + 8'(n));
         chk("wr strobe", 16'(n < 2 ? 1 : n), 16'(m_nwr));
         chk("wr addr phase", 16'(n + 2), 16'(m_nbz));
         chk("wr addr", 16'h0100 + 16'(n), m_adr);
         movx(3'h3, 8'h00, 8'h00);
         chk("rd strobe", 16'(n + 1), 16'(m_nrd));
         chk("rd addr phase", 16'(n + 1), 16'(m_nbz));
         chk("rd data", 16'h0050 + 16'(n), {8'h00, m_rd});
      end
      wr_reg(8'h8E, 8'h01);
      $display("test stretch done");
   endtask : t_stretch
   task automatic t_paged;
      wr_reg(8'hBF, 8'h20);
      movx(3'h2, 8'h34, 8'h5A);
      chk("paged addr", 16'h2034, m_adr);
      chk("paged sel", 16'h0004, {12'h000, m_sel});
      movx(3'h1, 8'h34, 8'h00);
      chk("paged data", 16'h005A, {8'h00, m_rd});
      $display("test paged done");
   endtask : t_paged
   task automatic t_decode;
      for (int i = 0; i < 10; i++) begin
         set_dp(dec_adr[i]);
         movx(3'h4, 8'h00, 8'hC0 + 8'(i));
         chk("decode sel", {12'h000, dec_sel[i]}, {12'h000, m_sel});
      end
      for (int i = 0; i < 8; i++) begin
         set_dp(dec_adr[i]);
         movx(3'h3, 8'h00, 8'h00);
         chk("decode data", 16'h00C0 + 16'(i), {8'h00, m_rd});
      end
      $display("test decode done");
   endtask : t_decode
   task automatic t_primary_data_pointer;
      pulse_op(3'h6, 8'h00, 8'h00, 16'h1234);
      wr_reg(8'h92, 8'h01);
      pulse_op(3'h6, 8'h00, 8'h00, 16'h2055);
      pulse_op(3'h5, 8'h00, 8'h00, 16'h0000);
      chk_reg("dp1 low", 8'h84, 8'h56);
      chk_reg("dp1 high", 8'h85, 8'h20);
      chk_reg("dp0 low", 8'h82, 8'h34);
      chk_reg("dp0 high", 8'h83, 8'h12);
      movx(3'h3, 8'h00, 8'h00);
      chk("dp1 addr", 16'h2056, m_adr);
      wr_reg(8'h92, 8'h00);
      pulse_op(3'h5, 8'h00, 8'h00, 16'h0000);
      chk_reg("dp0 inc", 8'h82, 8'h35);
      chk_reg("dp1 kept", 8'h84, 8'h56);
      $display("test pointers done");
   endtask : t_primary_data_pointer
   task automatic t_fetch;
      for (int k = 0; k < 8; k++) begin
         @(posedge mclk);
         fetch_req <= 1'b1;
         irq_take  <= 1'b1;
         irq_num   <= 3'(k);
         @(posedge mclk);
         fetch_req <= 1'b0;
         irq_take  <= 1'b0;
         wait_pc(16'h0003 + 16'(8 * k));
      end
      @(posedge mclk);
      fetch_req    <= 1'b1;
      fetch_branch <= 1'b1;
      @(posedge mclk);
      fetch_req    <= 1'b0;
      fetch_branch <= 1'b0;
      wait_pc(16'hFFFF);
      chk_reg("pc lo", 8'hC3, 8'hFF);
      chk_reg("pc hi", 8'hC4, 8'hFF);
      @(posedge mclk);
      fetch_req <= 1'b1;
      @(posedge mclk);
      fetch_req <= 1'b0;
      #1 chk("pc_fetch", 16'h0001, {15'h0000, pc_fetch});
      chk("pc wrap", 16'h0000, pc_addr);
      $display("test fetch done");
   endtask : t_fetch
   task automatic t_div;
      int cnt;
      cnt = 0;
      wr_reg(8'hC1, 8'h02);
      chk_reg("divider", 8'hC1, 8'h02);
      repeat (4) @(posedge mclk);
      for (int i = 0; i < 32; i++) begin
         @(posedge mclk);
         #1 cnt += int'(cpu_en_q === 1'b1);
      end
      chk("cpu enables", 16'h0008, 16'(cnt));
      $display("test divider done");
   endtask : t_div
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #200000;
      n_errors++;
      end_sim();
   end
   initial begin
      {rst_n, fetch_req, fetch_branch, irq_take, reg_wr, reg_rd} = 6'h00;
      {op, irq_num, ri_val, op_wdata, reg_addr, reg_wdata, dp_load} = 54'h0;
      fetch_target = 16'hFFFF;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      #1 t_reset();
      t_stretch();
      t_paged();
      t_decode();
      t_primary_data_pointer();
      t_fetch();
      t_div();
      end_sim();
   end
endmodule : mxa_core_tb
